// file: olcd_defs.svh
// Purpose : Shared constants for the opcode length and cycle decoder
// Assumes : Included by bare name from the decoder only
// Notes   : Definitions only
`ifndef OLCD_DEFS_SVH
`define OLCD_DEFS_SVH

// ---------------------------------------------------------------
// Opcodes with special handling
// ---------------------------------------------------------------
`define OLCD_OP_RESERVED   8'hA5
`define OLCD_OP_IDX_JUMP   8'h73
`define OLCD_OP_DIVIDE     8'h84
`define OLCD_OP_MULTIPLY   8'hA4
`define OLCD_OP_LOAD_DATA_POINTER  8'h90
`define OLCD_OP_ORL_A_IMM  8'h44

// ---------------------------------------------------------------
// Field positions, widths and counts
// ---------------------------------------------------------------
`define OLCD_LO_PAGE_JUMP  4'h1
`define OLCD_PAGE_BITS     11
`define OLCD_DISP_BITS     8
`define OLCD_SFR_BIT       7
`define OLCD_CYC_TWO       3'h2

`endif

// file: olcd_pkg.sv
// Purpose : Types of the opcode length and cycle decoder
// Assumes : Used by olcd_decoder and the bench
// Notes   : Constants live in olcd_defs.svh
package olcd_pkg;
  // Operation class
  typedef enum logic [3:0] {
    CLS_ALU, CLS_LOGIC, CLS_MOVE, CLS_BIT, CLS_JUMP, CLS_CALL,
    CLS_RETURN, CLS_BRANCH, CLS_MULDIV, CLS_NOP, CLS_ILLEGAL
  } olcd_class_t;
  // Operand addressing mode
  typedef enum logic [3:0] {
    M_NONE, M_REG, M_INDIRECT, M_DIRECT, M_IMM, M_BIT, M_IMM16,
    M_ADDR, M_INDEXED
  } olcd_mode_t;
  // Kind of branch target formed
  typedef enum logic [2:0] {
    T_NONE, T_PAGE, T_LONG, T_REL, T_INDEX
  } olcd_tgt_t;
  // One decoded opcode
  typedef struct packed {
    logic [1:0]  len;
    logic [2:0]  cyc;
    olcd_class_t cls;
    olcd_mode_t  mode;
    olcd_tgt_t   tgt;
  } olcd_info_t;
endpackage

// file: olcd_decoder.sv
// Purpose : First-byte decoder: length, class, mode, cycles, target
// Assumes : Fetch bytes and program counter synchronous to clk
// Notes   : One registered stage; a new opcode may come every cycle
`timescale 1ns/10ps
`include "olcd_defs.svh"

// Functional notes
// (RL1) Bit AND/OR into carry: 2 bytes, 2 cycles
// (RL2) Carry to bit 2/2; bit to carry 2/1
// (RL3) Page jump and call: 2 bytes, 2 cycles
// (RL4) Far jump and call: 3 bytes, 16-bit target
// (RL5) Relative target: next address plus signed byte
// (RL6) Bit branches 3/2; set form clears bit
// (RL7) Acc zero/nonzero, carry branches: 2 bytes, 2 cycles
// (RL8) Compare branches: 3 bytes, 2 cycles
// (RL9) Decrement branch: 2 cycles, 2 or 3 bytes
// (RL10) Opcode 73: indexed jump, pointer plus accumulator
// (RL11) Low nibble 1: page jump or call
// (RL12) Opcode A5 is reserved
// (RL13) Low nibble 8-F selects working register
// (RL14) Indirect pointer is register 0 or 1
// (RL15) Direct byte: low RAM or special register
// (RL16) Bit operand: software flag or special bit
// (RL17) Pointer load takes bytes two and three
// (RL18) Software never emits E5 on accumulator itself
// (RL19) 84 divide and A4 multiply are one byte
// (RL20) Page target from opcode, byte two, next PC
// (RL21) Reserved opcode flags illegal, acts one/one
module olcd_decoder
  import olcd_pkg::*;
#(
  parameter int ADDR_W = 16            // Program address width
)(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              fetch_valid,
  input  wire logic [7:0]        fetch_opcode,
  input  wire logic [7:0]        fetch_byte2,
  input  wire logic [7:0]        fetch_byte3,
  input  wire logic [ADDR_W-1:0] fetch_pc,
  input  wire logic [15:0]       data_pointer,
  input  wire logic [7:0]        accumulator_reg,
  output logic                   dec_valid,
  output logic [1:0]             dec_length,
  output logic [2:0]             dec_cycles,
  output olcd_class_t            dec_class,
  output olcd_mode_t             dec_mode,
  output logic [2:0]             dec_reg_sel,
  output logic                   dec_ptr_sel,
  output logic                   dec_ext_ram,
  output logic                   dec_sfr_operand,
  output logic                   dec_illegal,
  output logic                   dec_clears_bit,
  output logic                   dec_target_valid,
  output logic [ADDR_W-1:0]      dec_target,
  output logic [15:0]            dec_imm16
);

  // -------------------------------------------------------------
  // Elaboration check
  // -------------------------------------------------------------
  // The far forms carry exactly sixteen address bits
  if (ADDR_W != 16) begin : g_bad_width
    $error("olcd_decoder: ADDR_W must be 16");
  end

  // -------------------------------------------------------------
  // Decode helpers
  // -------------------------------------------------------------
  // Packs one table entry
  function automatic olcd_info_t mk(input int l, input int c,
                                    input olcd_class_t k,
                                    input olcd_mode_t m,
                                    input olcd_tgt_t t);
    olcd_info_t r;
    r.len  = 2'(l);
    r.cyc  = 3'(c);
    r.cls  = k;
    r.mode = m;
    r.tgt  = t;
    return r;
  endfunction

  // Full decode of one opcode
  function automatic olcd_info_t decode(input logic [7:0] op);
    olcd_info_t d;
    d = mk(1, 1, CLS_ALU, M_NONE, T_NONE);
    if (op[3:0] == `OLCD_LO_PAGE_JUMP) begin
      // Odd high nibble calls, even one jumps
      d = mk(2, 2, op[4] ? CLS_CALL : CLS_JUMP, M_ADDR, T_PAGE); // RL3 RL11
    end else if (op == `OLCD_OP_RESERVED) begin
      // Harmless one-byte, one-cycle slot
      d = mk(1, 1, CLS_ILLEGAL, M_NONE, T_NONE); // RL12 RL21
    end else if (op[3] || op[3:1] == 3'h3) begin
      // Register (8-F) and indirect (6-7) columns share rows
      d.mode = op[3] ? M_REG : M_INDIRECT; // RL13 RL14
      unique case (op[7:4])
        4'h4, 4'h5, 4'h6: d.cls = CLS_LOGIC;
        4'h7: begin
          d.len = 2'h2;
          d.cls = CLS_MOVE;
        end
        4'h8, 4'hA: begin
          d.len = 2'h2;
          d.cyc = `OLCD_CYC_TWO;
          d.cls = CLS_MOVE;
        end
        4'hB: begin
          d.len = 2'h3;
          d.cyc = `OLCD_CYC_TWO;
          d.cls = CLS_BRANCH;
          d.tgt = T_REL; // RL8
        end
        4'hD: begin
          if (op[3]) begin
            d.len = 2'h2;
            d.cyc = `OLCD_CYC_TWO;
            d.cls = CLS_BRANCH;
            d.tgt = T_REL; // RL9
          end else begin
            d.cls = CLS_MOVE;
          end
        end
        4'hC, 4'hE, 4'hF: d.cls = CLS_MOVE;
        default: d.cls = CLS_ALU;
      endcase
    end else if (!op[7] && op[6:4] != 3'h7 && op[3:0] == 4'h5) begin
      // Direct-byte arithmetic and logic; the immediate-to-direct move
      // in row 7 is three bytes and must fall through to the table
      d = mk(2, 1, op[6] ? CLS_LOGIC : CLS_ALU, M_DIRECT, T_NONE);
    end else if (!op[7] && op[6:4] != 3'h7 && op[3:0] == 4'h4) begin
      // Accumulator step or immediate operand
      if (op[6:5] == 2'h0) begin
        d = mk(1, 1, CLS_ALU, M_NONE, T_NONE);
      end else begin
        d = mk(2, 1, op[6] ? CLS_LOGIC : CLS_ALU, M_IMM, T_NONE);
        if (op == `OLCD_OP_ORL_A_IMM) begin
          d.cyc = `OLCD_CYC_TWO;
        end
      end
    end else begin
      unique case (op)
        8'h00: d = mk(1, 1, CLS_NOP, M_NONE, T_NONE);
        8'h02: d = mk(3, 2, CLS_JUMP, M_ADDR, T_LONG); // RL4
        8'h12: d = mk(3, 2, CLS_CALL, M_ADDR, T_LONG); // RL4
        8'h10, 8'h20, 8'h30:
          d = mk(3, 2, CLS_BRANCH, M_BIT, T_REL); // RL6
        8'h22, 8'h32: d = mk(1, 2, CLS_RETURN, M_NONE, T_NONE);
        8'h40, 8'h50, 8'h60, 8'h70:
          d = mk(2, 2, CLS_BRANCH, M_NONE, T_REL); // RL7
        8'h42, 8'h52, 8'h62:
          d = mk(2, 1, CLS_LOGIC, M_DIRECT, T_NONE);
        8'h43, 8'h53, 8'h63:
          d = mk(3, 2, CLS_LOGIC, M_DIRECT, T_NONE);
        8'h72, 8'h82, 8'hA0, 8'hB0:
          d = mk(2, 2, CLS_BIT, M_BIT, T_NONE); // RL1
        8'h73: d = mk(1, 2, CLS_JUMP, M_INDEXED, T_INDEX); // RL10
        8'h74: d = mk(2, 1, CLS_MOVE, M_IMM, T_NONE);
        8'h75, 8'h85:
          d = mk(3, 2, CLS_MOVE, M_DIRECT, T_NONE);
        8'h80: d = mk(2, 2, CLS_JUMP, M_NONE, T_REL); // RL5
        8'h83, 8'h93:
          d = mk(1, 2, CLS_MOVE, M_INDEXED, T_NONE);
        8'h84, 8'hA4:
          d = mk(1, 4, CLS_MULDIV, M_NONE, T_NONE); // RL19
        8'h90: d = mk(3, 2, CLS_MOVE, M_IMM16, T_NONE); // RL17
        8'h92: d = mk(2, 2, CLS_BIT, M_BIT, T_NONE); // RL2
        8'hA2: d = mk(2, 1, CLS_BIT, M_BIT, T_NONE); // RL2
        8'h94: d = mk(2, 1, CLS_ALU, M_IMM, T_NONE);
        8'h95: d = mk(2, 1, CLS_ALU, M_DIRECT, T_NONE);
        8'hA3: d = mk(1, 2, CLS_ALU, M_NONE, T_NONE);
        8'hB2, 8'hC2, 8'hD2:
          d = mk(2, 1, CLS_BIT, M_BIT, T_NONE); // RL16
        8'hB3, 8'hC3, 8'hD3:
          d = mk(1, 1, CLS_BIT, M_NONE, T_NONE);
        8'hB4: d = mk(3, 2, CLS_BRANCH, M_IMM, T_REL); // RL8
        8'hB5: d = mk(3, 2, CLS_BRANCH, M_DIRECT, T_REL); // RL8
        8'hC0, 8'hD0:
          d = mk(2, 2, CLS_MOVE, M_DIRECT, T_NONE);
        8'hC5, 8'hE5, 8'hF5:
          d = mk(2, 1, CLS_MOVE, M_DIRECT, T_NONE); // RL15
        8'hD5: d = mk(3, 2, CLS_BRANCH, M_DIRECT, T_REL); // RL9
        8'hE0, 8'hF0:
          d = mk(1, 2, CLS_MOVE, M_NONE, T_NONE);
        8'hE2, 8'hE3, 8'hF2, 8'hF3:
          d = mk(1, 2, CLS_MOVE, M_INDIRECT, T_NONE); // RL14
        default: d = mk(1, 1, CLS_ALU, M_NONE, T_NONE);
      endcase
    end
    return d;
  endfunction

  // -------------------------------------------------------------
  // Combinational decode of the presented bytes
  // -------------------------------------------------------------
  olcd_info_t          info;        // Table entry for the opcode
  logic [ADDR_W-1:0]   pc_after;    // First byte of next instruction
  logic [7:0]          disp;        // Relative offset byte
  logic [ADDR_W-1:0]   next_target; // Target before registering
  logic                ext_move;    // External data move forms

  always_comb begin
    info     = decode(fetch_opcode);
    pc_after = fetch_pc + ADDR_W'(info.len);
    // Three-byte branches carry the offset in the last byte
    disp     = (info.len == 2'h3) ? fetch_byte3 : fetch_byte2;
    ext_move = (fetch_opcode[7:5] == 3'h7) &&
               (fetch_opcode[3:0] == 4'h0 ||
                fetch_opcode[3:1] == 3'h1);
  end

  // Target formation per form
  always_comb begin
    unique case (info.tgt)
      T_PAGE: next_target = {pc_after[ADDR_W-1:`OLCD_PAGE_BITS],
                             fetch_opcode[7:5], fetch_byte2}; // RL20
      T_LONG: next_target = {fetch_byte2, fetch_byte3}; // RL4
      // Wraps inside the address space, as the counter does
      T_REL:  next_target = pc_after +
                {{(ADDR_W-`OLCD_DISP_BITS){disp[7]}}, disp}; // RL5
      T_INDEX: next_target = data_pointer +
                ADDR_W'(accumulator_reg); // RL10
      default: next_target = '0;
    endcase
  end

  // -------------------------------------------------------------
  // Registered outputs
  // -------------------------------------------------------------
  // Valid follows the fetch strobe by one edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dec_valid <= 1'b0;
    end else begin
      dec_valid <= fetch_valid;
    end
  end

  // Length, cycles, class and mode; held while idle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dec_length  <= 2'h1;
      dec_cycles  <= 3'h1;
      dec_class   <= CLS_NOP;
      dec_mode    <= M_NONE;
      dec_illegal <= 1'b0;
    end else if (fetch_valid) begin
      dec_length  <= info.len;
      dec_cycles  <= info.cyc;
      dec_class   <= info.cls;
      dec_mode    <= info.mode;
      dec_illegal <= (info.cls == CLS_ILLEGAL); // RL21
    end
  end

  // Operand selectors
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dec_reg_sel     <= 3'h0;
      dec_ptr_sel     <= 1'b0;
      dec_ext_ram     <= 1'b0;
      dec_sfr_operand <= 1'b0;
      dec_clears_bit  <= 1'b0;
    end else if (fetch_valid) begin
      dec_reg_sel     <= fetch_opcode[2:0]; // RL13
      dec_ptr_sel     <= fetch_opcode[0]; // RL14
      dec_ext_ram     <= ext_move; // RL14
      // High half of the space names special registers or bits
      dec_sfr_operand <= (info.mode == M_DIRECT ||
                          info.mode == M_BIT) &&
                         fetch_byte2[`OLCD_SFR_BIT]; // RL15 RL16
      dec_clears_bit  <= (fetch_opcode == 8'h10); // RL6
    end
  end

  // Branch target and sixteen-bit constant
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dec_target_valid <= 1'b0;
      dec_target       <= '0;
      dec_imm16        <= 16'h0000;
    end else if (fetch_valid) begin
      dec_target_valid <= (info.tgt != T_NONE);
      dec_target       <= next_target;
      dec_imm16        <= {fetch_byte2, fetch_byte3}; // RL17
    end
  end

  // -------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_take(logic [7:0] op);
    fetch_valid && fetch_opcode == op;
  endsequence

  sequence s_page_take;
    fetch_valid && fetch_opcode[3:0] == `OLCD_LO_PAGE_JUMP;
  endsequence

  AST_BIT_TO_CARRY: assert property ( // RL1
    (s_take(8'h82) or s_take(8'hB0) or s_take(8'h72) or
     s_take(8'hA0)) |=> dec_length == 2'h2 && dec_cycles == 3'h2)
    else $error("bit logic into carry not 2/2");

  AST_CARRY_MOVES: assert property ( // RL2
    s_take(8'hA2) |=> dec_length == 2'h2 && dec_cycles == 3'h1)
    else $error("bit to carry not 2/1");

  AST_PAGE_FORM: assert property ( // RL3
    s_page_take |=> dec_length == 2'h2 && dec_cycles == 3'h2 &&
      dec_class == ($past(fetch_opcode[4]) ? CLS_CALL : CLS_JUMP))
    else $error("page jump or call misdecoded");

  AST_PAGE_TARGET: assert property ( // RL20
    s_page_take |=> dec_target[10:8] == $past(fetch_opcode[7:5]) &&
      dec_target[7:0] == $past(fetch_byte2) &&
      dec_target[15:11] == $past(fetch_pc[15:11] + 5'(
        ({5'h0, fetch_pc[10:0]} + 16'h2) >> 11)))
    else $error("page target bits wrong");

  AST_FAR_TARGET: assert property ( // RL4
    (s_take(8'h02) or s_take(8'h12)) |=> dec_length == 2'h3 &&
      dec_target == {$past(fetch_byte2), $past(fetch_byte3)})
    else $error("far target wrong");

  AST_REL_REACH: assert property ( // RL5
    s_take(8'h80) |=> dec_target == $past(fetch_pc) + 16'h2 +
      {{8{$past(fetch_byte2[7])}}, $past(fetch_byte2)})
    else $error("relative target wrong");

  AST_DEC_BRANCH: assert property ( // RL9
    fetch_valid && fetch_opcode[7:3] == 5'h1B |=>
      dec_length == 2'h2 && dec_cycles == 3'h2 && dec_target_valid)
    else $error("register decrement branch not 2/2");

  AST_INDEX_JUMP: assert property ( // RL10
    s_take(8'h73) |=> dec_length == 2'h1 && dec_target ==
      $past(data_pointer) + {8'h00, $past(accumulator_reg)})
    else $error("indexed jump target wrong");

  AST_RESERVED: assert property ( // RL21
    s_take(`OLCD_OP_RESERVED) |=> dec_illegal && dec_length == 2'h1 &&
      dec_cycles == 3'h1 ##1 !dec_valid || !dec_illegal ||
      $past(fetch_opcode) == `OLCD_OP_RESERVED)
    else $error("reserved opcode not flagged");

  AST_MULDIV: assert property ( // RL19
    (s_take(8'h84) or s_take(8'hA4)) |=> dec_class == CLS_MULDIV &&
      dec_length == 2'h1)
    else $error("multiply or divide misdecoded");

endmodule

// file: olcd_fetch_model.sv
// Purpose : Program fetch stage model that feeds whole instructions to the decoder
// Assumes : The bench queues entries packed as {op, byte2, byte3, pc, data_pointer, acc}
// Notes   : Idle cycles show inverted bytes, so a decoder that samples them is caught
`timescale 1ns/10ps
module olcd_fetch_model (
  input  wire logic        clk,
  output logic             fetch_valid,
  output logic [7:0]       fetch_opcode,
  output logic [7:0]       fetch_byte2,
  output logic [7:0]       fetch_byte3,
  output logic [15:0]      fetch_pc,
  output logic [15:0]      data_pointer,
  output logic [7:0]       accumulator_reg
);
  logic [63:0] pend [$];   // Instructions waiting for the bus
  logic [63:0] cur;        // Entry that goes out at this edge

  // ---------------------------------------------------------------
  // Start-up values
  // ---------------------------------------------------------------
  initial begin
    fetch_valid = 1'b0;
    {fetch_opcode, fetch_byte2, fetch_byte3, fetch_pc, data_pointer, accumulator_reg} = '0;
  end

  // ---------------------------------------------------------------
  // One whole instruction per cycle, no hold of stale bytes
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (pend.size() > 0) begin
      // Opcode and all operand bytes travel together
      cur = pend.pop_front();
      fetch_valid <= 1'b1;
      {fetch_opcode, fetch_byte2, fetch_byte3, fetch_pc, data_pointer, accumulator_reg} <= cur;
    end else begin
      // Nothing to present: scramble the lines
      fetch_valid <= 1'b0;
      {fetch_opcode, fetch_byte2, fetch_byte3, fetch_pc, data_pointer, accumulator_reg} <=
        ~{fetch_opcode, fetch_byte2, fetch_byte3, fetch_pc, data_pointer, accumulator_reg};
    end
  end
endmodule

// file: opcode_length_cycle_decoder_tb.sv
// Purpose : Self-checking bench for the opcode length and cycle decoder
// Assumes : Decode appears one cycle after each presented instruction
// Notes   : Every opcode goes through twice with random operands and gaps
`timescale 1ns/10ps
module opcode_length_cycle_decoder_tb
  import olcd_pkg::*;
;
  localparam logic [7:0] ACC_ADDR = 8'hE0;  // Direct address of the accumulator

  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic              fetch_valid;
  logic [7:0]        fetch_opcode, fetch_byte2, fetch_byte3, accumulator_reg;
  logic [15:0]       fetch_pc, data_pointer, dec_target, dec_imm16;
  logic              dec_valid, dec_ptr_sel, dec_ext_ram, dec_sfr_operand;
  logic              dec_illegal, dec_clears_bit, dec_target_valid;
  logic [1:0]        dec_length;
  logic [2:0]        dec_cycles, dec_reg_sel;
  olcd_class_t       dec_class;
  olcd_mode_t        dec_mode;
  int                miscompares = 0;  // Mismatch count
  int                tests_run = 0;    // Comparison count
  int                seed = 32'h2067;  // Fixed random seed
  logic [63:0]       exp_q [$];        // Instructions awaiting their decode

  always #2.5 clk = ~clk;

  olcd_fetch_model olcd_fetch_model_i (.clk(clk), .fetch_valid(fetch_valid),
    .fetch_opcode(fetch_opcode), .fetch_byte2(fetch_byte2), .fetch_byte3(fetch_byte3),
    .fetch_pc(fetch_pc), .data_pointer(data_pointer), .accumulator_reg(accumulator_reg));

  olcd_decoder #(.ADDR_W(16)) olcd_decoder_i (.clk(clk), .rst(rst),
    .fetch_valid(fetch_valid), .fetch_opcode(fetch_opcode), .fetch_byte2(fetch_byte2),
    .fetch_byte3(fetch_byte3), .fetch_pc(fetch_pc), .data_pointer(data_pointer),
    .accumulator_reg(accumulator_reg), .dec_valid(dec_valid), .dec_length(dec_length),
    .dec_cycles(dec_cycles), .dec_class(dec_class), .dec_mode(dec_mode),
    .dec_reg_sel(dec_reg_sel), .dec_ptr_sel(dec_ptr_sel), .dec_ext_ram(dec_ext_ram),
    .dec_sfr_operand(dec_sfr_operand), .dec_illegal(dec_illegal),
    .dec_clears_bit(dec_clears_bit), .dec_target_valid(dec_target_valid),
    .dec_target(dec_target), .dec_imm16(dec_imm16));

  // ---------------------------------------------------------------
  // Shared compare and verdict
  // ---------------------------------------------------------------
  task automatic check(input logic [16:0] seen, input logic [16:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("Counts: %0d comparisons, %0d mismatches", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Reference model: {length, cycles}, FF where not pinned down
  // ---------------------------------------------------------------
  function automatic logic [7:0] exp_lc(input logic [7:0] op);
    case (op) inside
      8'h00, 8'hA5:                          return 8'h11;
      8'h72, 8'h82, 8'hA0, 8'hB0, 8'h92:     return 8'h22;
      8'hA2:                                 return 8'h21;
      8'h02, 8'h12:                          return 8'h32;
      8'h40, 8'h50, 8'h60, 8'h70, 8'h80:     return 8'h22;
      8'h73:                                 return 8'h12;
      8'h10, 8'h20, 8'h30:                   return 8'h32;
      [8'hB4:8'hBF]:                         return 8'h32;
      8'hD5, 8'h90:                          return 8'h32;
      8'h75:                                 return 8'h32;  // Immediate to direct byte
      [8'hD8:8'hDF]:                         return 8'h22;
      8'h84, 8'hA4:                          return 8'h14;
      default: return (op[3:0] == 4'h1) ? 8'h22 : 8'hFF;
    endcase
  endfunction

  // Reference target as {valid, address}
  function automatic logic [16:0] exp_tgt(input logic [63:0] e);
    logic [7:0]  op, b2, b3, ac;
    logic [15:0] pc, dp, nx;
    {op, b2, b3, pc, dp, ac} = e;
    nx = pc + 16'h0002;
    if (op[3:0] == 4'h1) return {1'b1, nx[15:11], op[7:5], b2};
    case (op) inside
      8'h02, 8'h12:                 return {1'b1, b2, b3};
      8'h73:                        return {1'b1, dp + {8'h00, ac}};
      8'h40, 8'h50, 8'h60, 8'h70, 8'h80, [8'hD8:8'hDF]:
        return {1'b1, nx + {{8{b2[7]}}, b2}};
      8'h10, 8'h20, 8'h30, 8'hD5, [8'hB4:8'hBF]:
        return {1'b1, pc + 16'h0003 + {{8{b3[7]}}, b3}};
      default:                      return 17'h00000;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // Compare every decode against the model
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    logic [63:0] e;
    logic [7:0]  op, b2, b3, lc;
    if (!rst && dec_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        check(17'(dec_valid), 17'h00000);  // Decode with no instruction behind it
      end else begin
        e = exp_q.pop_front();
        {op, b2, b3} = e[63:40];
        lc = exp_lc(op);
        if (lc != 8'hFF) begin
          check(17'(dec_length), 17'(lc[7:4]));
          check(17'(dec_cycles), 17'(lc[3:0]));
        end
        // Returns may or may not report their stack target
        if (op != 8'h22 && op != 8'h32) check({dec_target_valid, dec_target}, exp_tgt(e));
        check(17'(dec_illegal), 17'(op == 8'hA5));
        if (op == 8'hA5) check(17'(dec_class), 17'(CLS_ILLEGAL));
        check(17'(dec_clears_bit), 17'(op == 8'h10));
        if (op[3]) check(17'(dec_reg_sel), 17'(op[2:0]));
        if (op inside {[8'h08:8'h0F]}) check(17'(dec_mode), 17'(M_REG));
        if (op inside {8'h06, 8'h07, 8'hE2, 8'hE3}) check(17'(dec_ptr_sel), 17'(op[0]));
        check(17'(dec_ext_ram), 17'(op inside {8'hE0, 8'hE2, 8'hE3, 8'hF0, 8'hF2, 8'hF3}));
        if (op inside {8'h05, 8'hE5, 8'h72, 8'h82, 8'hA0, 8'hB0, 8'hA2, 8'h92, 8'hC2})
          check(17'(dec_sfr_operand), 17'(b2[7]));
        if (op == 8'h90) check(17'(dec_imm16), 17'({b2, b3}));
        if (op inside {8'h84, 8'hA4}) check(17'(dec_class), 17'(CLS_MULDIV));
      end
    end
  end

  // ---------------------------------------------------------------
  // Stimulus: queue one instruction, sometimes leave an idle cycle
  // ---------------------------------------------------------------
  task automatic issue(input logic [7:0] op);
    logic [63:0] e;
    e = {op, 8'($random(seed)), 8'($random(seed)), 16'($random(seed)),
         16'($random(seed)), 8'($random(seed))};
    if (op == 8'hE5 && e[55:48] == ACC_ADDR) e[55:48] = 8'h30;
    @(negedge clk);
    olcd_fetch_model_i.pend.push_back(e);
    exp_q.push_back(e);
    if (($random(seed) & 3) == 0) @(negedge clk);
  endtask

  // Reset values as seen at the ports
  task automatic check_reset();
    check(17'(dec_valid), 17'h00000);
    check(17'(dec_length), 17'h00001);
    check(17'(dec_cycles), 17'h00001);
    check(17'(dec_class), 17'(CLS_NOP));
    check({dec_target_valid, dec_target}, 17'h00000);
  endtask

  task automatic drain();
    int n;
    n = 0;
    while (exp_q.size() > 0 && n < 100) begin
      @(posedge clk);
      n++;
    end
    if (exp_q.size() > 0) check(17'(exp_q.size()), 17'h00000);  // Decodes went missing
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check_reset();
    // Every opcode twice, back to back with random gaps
    for (int pass = 0; pass < 2; pass++) begin
      for (int i = 0; i < 256; i++) issue(8'(i));
    end
    drain();
    // Second reset in mid-run clears the decode
    @(posedge clk);
    rst <= 1'b1;
    @(negedge clk);
    check_reset();
    @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 16; i++) issue({i[3:0], 4'h1});
    drain();
    final_report();
  end

  // Overall limit on the run
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    final_report();
  end
endmodule
